// *** inc/cgsf_pkg.sv ***
// Purpose: Shared constants for the clock generator status, filter and trim block
// Assumes: 10 MHz system clock, 8-bit register port with word index addressing
// Notes: Offsets and timing figures of the design are named here; the bench writes its clock period and unmapped index as literals
package cgsf_pkg;
  // Register indexes on the plain register port
  localparam logic [2:0] ADDR_STATUS_ONE = 3'h0;
  localparam logic [2:0] ADDR_STATUS_TWO = 3'h1;
  localparam logic [2:0] ADDR_FILTER_UPPER = 3'h2;
  localparam logic [2:0] ADDR_FILTER_LOWER = 3'h3;
  localparam logic [2:0] ADDR_PERIOD_ADJUST = 3'h4;
  // Clock mode codes
  localparam logic [1:0] MODE_SELF = 2'h0;
  localparam logic [1:0] MODE_LOOP_INT = 2'h1;
  localparam logic [1:0] MODE_BYPASS_EXT = 2'h2;
  localparam logic [1:0] MODE_LOOP_EXT = 2'h3;
  // Field positions in status one and status two, and the filter upper field width
  localparam int POS_MODE_LO = 6;
  localparam int POS_REF_IN_USE = 5;
  localparam int POS_SLIP = 4;
  localparam int POS_LOCK = 3;
  localparam int POS_REF_LOSS = 2;
  localparam int POS_EXT_OK = 1;
  localparam int POS_IRQ = 0;
  localparam int POS_OSC_STABLE = 0;
  localparam int FILTER_UPPER_W = 4;
  // Reset values
  localparam logic [7:0] TRIM_RESET = 8'h80;
  localparam logic [11:0] FILTER_RESET = 12'h000;
  localparam logic [7:0] READ_IDLE = 8'h00;
  // Timing: clock domain crossing and filter latch sequence
  localparam int CLK_PERIOD_NS = 100;
  localparam int SYNC_TIME_NS = 200;
  localparam int LATCH_TIME_NS = 300;
  localparam int SYNC_CYCLES = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LATCH_CYCLES = (LATCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] SYNC_CNT = 2'(SYNC_CYCLES);
  localparam logic [1:0] LATCH_CNT = 2'(LATCH_CYCLES);
  localparam logic [1:0] CNT_ZERO = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;
  // Oscillator stability check
  localparam logic [11:0] UNLOCK_TOL = 12'h004;
  localparam logic [1:0] STABLE_SAMPLES = 2'h2;
  // Mode status sequencer
  typedef enum logic [1:0] {MS_IDLE, MS_SYNC, MS_WAIT} cgsf_mode_state_type;
endpackage

// *** design/cgsf_stable_detect.sv ***
// Purpose: Oscillator stability detector for the clock generator
// Assumes: One count error sample per i_sample pulse
// Notes: Cleared while the generator sits in the off state
`timescale 1ns/1ns
`default_nettype none
module cgsf_stable_detect (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sample,
  input wire logic [11:0] i_count_error,
  input wire logic i_osc_static,
  input wire logic i_clear,
  output logic o_stable
);
  logic [11:0] prev_error;
  logic [1:0] good_count;
  logic [11:0] delta;
  logic sample_ok;

  // Absolute change of the count error and tolerance check
  assign delta = (i_count_error >= prev_error) ? (i_count_error - prev_error)
                                               : (prev_error - i_count_error);
  assign sample_ok = (delta <= cgsf_pkg::UNLOCK_TOL) && !i_osc_static;

  // Two consecutive good samples make the oscillator stable
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_error <= 12'h000;
      good_count <= cgsf_pkg::CNT_ZERO;
      o_stable <= 1'b0;
    end else if (i_clear) begin
      good_count <= cgsf_pkg::CNT_ZERO; // Off state clears it
      o_stable <= 1'b0;
    end else if (i_sample) begin
      prev_error <= i_count_error;
      if (!sample_ok) begin
        good_count <= cgsf_pkg::CNT_ZERO;
        o_stable <= 1'b0;
      end else if (good_count != cgsf_pkg::STABLE_SAMPLES) begin
        good_count <= good_count + cgsf_pkg::CNT_ONE;
        o_stable <= (good_count + cgsf_pkg::CNT_ONE) == cgsf_pkg::STABLE_SAMPLES;
      end
    end
  end
endmodule
`default_nettype wire

// *** design/cgsf_top.sv ***
// Purpose: Status, flag, filter word and trim registers of the clock generator
// Assumes: Control register fields and loop events arrive as synchronous inputs
// Notes: Register port answers every read one cycle later, never stalls
`timescale 1ns/1ns
`default_nettype none
module cgsf_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [1:0] i_mode_select,
  input wire logic i_mode_write,
  input wire logic i_off_state,
  input wire logic i_ref_select,
  input wire logic i_slip_reset_select,
  input wire logic i_ref_loss_reset_select,
  input wire logic i_lock_raw,
  input wire logic i_slip_event,
  input wire logic i_loss_event,
  input wire logic i_ext_ref_ok_raw,
  input wire logic i_err_sample,
  input wire logic [11:0] i_count_error,
  input wire logic i_osc_static,
  input wire logic [11:0] i_loop_filter,
  output logic [1:0] o_mode_status,
  output logic [11:0] o_filter_word,
  output logic [7:0] o_trim,
  output logic o_irq,
  output logic o_reset_req,
  output logic o_osc_monitor_en
);
  cgsf_pkg::cgsf_mode_state_type state;
  cgsf_pkg::cgsf_mode_state_type next_state;
  logic [1:0] mode_status;
  logic [1:0] target_mode;
  logic [1:0] sync_count;
  logic off_delay;
  logic reference_in_use;
  logic fll_slip_sticky;
  logic ref_loss_sticky;
  logic lock;
  logic ext_ref_ok;
  logic gen_irq_flag;
  logic clear_armed;
  logic [7:0] filter_low_shadow;
  logic [11:0] filter_word;
  logic [1:0] latch_count;
  logic [7:0] trim;
  logic osc_stable_flag;
  logic off_delay_seen;

  // Register port decode
  logic wr_status_one;
  logic rd_status_one;
  logic wr_upper;
  logic wr_lower;
  logic wr_trim;
  logic self_select;
  logic latch_busy;
  logic irq_event;
  logic reset_event;
  logic flag_clear;
  logic off_exit;
  logic target_ready;
  logic engaged;
  logic [7:0] status_one;
  logic [7:0] status_two;
  logic [7:0] read_mux;

  assign wr_status_one = i_wr && (i_addr == cgsf_pkg::ADDR_STATUS_ONE);
  assign rd_status_one = i_rd && (i_addr == cgsf_pkg::ADDR_STATUS_ONE);
  assign wr_upper = i_wr && (i_addr == cgsf_pkg::ADDR_FILTER_UPPER);
  assign wr_lower = i_wr && (i_addr == cgsf_pkg::ADDR_FILTER_LOWER);
  assign wr_trim = i_wr && (i_addr == cgsf_pkg::ADDR_PERIOD_ADJUST);
  assign self_select = (i_mode_select == cgsf_pkg::MODE_SELF);
  assign latch_busy = (latch_count != cgsf_pkg::CNT_ZERO);

  // Event routing: interrupt or reset by each select bit
  assign irq_event = (i_slip_event && !i_slip_reset_select) ||
                     (i_loss_event && !i_ref_loss_reset_select);
  assign reset_event = (i_slip_event && i_slip_reset_select) ||
                       (i_loss_event && i_ref_loss_reset_select);
  // Completed clear, unless a new event restarts the sequence
  assign flag_clear = wr_status_one && i_wdata[cgsf_pkg::POS_IRQ] &&
                      clear_armed && !irq_event;

  // Mode sequencer conditions
  assign off_exit = off_delay && !i_off_state;
  assign target_ready = (target_mode != cgsf_pkg::MODE_BYPASS_EXT || ext_ref_ok) &&
                        (!target_mode[0] || osc_stable_flag || !(off_delay_seen || off_delay));
  assign engaged = (mode_status == cgsf_pkg::MODE_LOOP_INT) ||
                   (mode_status == cgsf_pkg::MODE_LOOP_EXT);

  // Tracks that the pending switch came out of off
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      off_delay_seen <= 1'b0;
    end else if (off_exit) begin
      off_delay_seen <= 1'b1;
    end else if (state == cgsf_pkg::MS_WAIT && target_ready) begin
      off_delay_seen <= 1'b0;
    end
  end

  // Next state of the mode sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      cgsf_pkg::MS_IDLE: begin
        if (off_exit) begin
          next_state = cgsf_pkg::MS_WAIT;
        end else if (i_mode_write) begin
          next_state = cgsf_pkg::MS_SYNC;
        end
      end
      cgsf_pkg::MS_SYNC: begin
        if (sync_count == cgsf_pkg::CNT_ONE) begin
          next_state = cgsf_pkg::MS_WAIT;
        end
      end
      cgsf_pkg::MS_WAIT: begin
        if (target_ready && !i_off_state) begin
          next_state = cgsf_pkg::MS_IDLE;
        end
      end
      default: next_state = cgsf_pkg::MS_IDLE;
    endcase
  end

  // Mode status updates after the crossing delay on a mode write; leaving off goes straight to wait
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= cgsf_pkg::MS_IDLE;
      mode_status <= cgsf_pkg::MODE_SELF;
      target_mode <= cgsf_pkg::MODE_SELF;
      sync_count <= cgsf_pkg::CNT_ZERO;
      off_delay <= 1'b0;
    end else begin
      state <= next_state;
      off_delay <= i_off_state;
      if (state == cgsf_pkg::MS_IDLE && (i_mode_write || off_exit)) begin
        target_mode <= i_mode_select;
        sync_count <= cgsf_pkg::SYNC_CNT;
      end else if (sync_count != cgsf_pkg::CNT_ZERO) begin
        sync_count <= sync_count - cgsf_pkg::CNT_ONE;
      end
      if (state == cgsf_pkg::MS_WAIT && target_ready && !i_off_state) begin
        mode_status <= target_mode;
      end
    end
  end

  // Live status bits sampled from the generator
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      reference_in_use <= 1'b0;
      lock <= 1'b0;
      ext_ref_ok <= 1'b0;
    end else begin
      reference_in_use <= i_ref_select;
      lock <= i_lock_raw && engaged && !i_off_state;
      ext_ref_ok <= i_ext_ref_ok_raw;
    end
  end

  // Sticky flags, interrupt flag and its clear sequence; set beats clear
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fll_slip_sticky <= 1'b0;
      ref_loss_sticky <= 1'b0;
      gen_irq_flag <= 1'b0;
      clear_armed <= 1'b0;
    end else begin
      fll_slip_sticky <= i_slip_event || (fll_slip_sticky && !flag_clear);
      ref_loss_sticky <= i_loss_event || (ref_loss_sticky && !flag_clear);
      gen_irq_flag <= irq_event || (gen_irq_flag && !flag_clear);
      if (irq_event || flag_clear) begin
        clear_armed <= 1'b0;
      end else if (rd_status_one && gen_irq_flag) begin
        clear_armed <= 1'b1;
      end
    end
  end

  // Filter word: shadow low byte, upper write latches all twelve bits
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      filter_low_shadow <= 8'h00;
      filter_word <= cgsf_pkg::FILTER_RESET;
      latch_count <= cgsf_pkg::CNT_ZERO;
    end else begin
      if (wr_lower && self_select) begin
        filter_low_shadow <= i_wdata;
      end
      if (!self_select) begin
        filter_word <= i_loop_filter;
      end else if (wr_upper && !latch_busy) begin
        filter_word <= {i_wdata[cgsf_pkg::FILTER_UPPER_W-1:0], filter_low_shadow};
        latch_count <= cgsf_pkg::LATCH_CNT;
      end
      if (latch_busy) begin
        latch_count <= latch_count - cgsf_pkg::CNT_ONE;
      end
    end
  end

  // Trim byte, freely written
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      trim <= cgsf_pkg::TRIM_RESET;
    end else if (wr_trim) begin
      trim <= i_wdata;
    end
  end

  // Oscillator stability check
  cgsf_stable_detect u_stable (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_sample(i_err_sample),
    .i_count_error(i_count_error),
    .i_osc_static(i_osc_static),
    .i_clear(i_off_state),
    .o_stable(osc_stable_flag)
  );

  // Status images and read selection
  assign status_one = {mode_status, reference_in_use, fll_slip_sticky, lock,
                       ref_loss_sticky, ext_ref_ok, gen_irq_flag};
  assign status_two = {7'h00, osc_stable_flag};
  assign read_mux = (i_addr == cgsf_pkg::ADDR_STATUS_ONE) ? status_one :
                    (i_addr == cgsf_pkg::ADDR_STATUS_TWO) ? status_two :
                    (i_addr == cgsf_pkg::ADDR_FILTER_UPPER) ? {4'h0, filter_word[11:8]} :
                    (i_addr == cgsf_pkg::ADDR_FILTER_LOWER) ? filter_word[7:0] :
                    (i_addr == cgsf_pkg::ADDR_PERIOD_ADJUST) ? trim :
                    cgsf_pkg::READ_IDLE;

  // Registered outputs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= cgsf_pkg::READ_IDLE;
      o_mode_status <= cgsf_pkg::MODE_SELF;
      o_filter_word <= cgsf_pkg::FILTER_RESET;
      o_trim <= cgsf_pkg::TRIM_RESET;
      o_irq <= 1'b0;
      o_reset_req <= 1'b0;
      o_osc_monitor_en <= 1'b0;
    end else begin
      o_rdata <= i_rd ? read_mux : cgsf_pkg::READ_IDLE;
      o_mode_status <= mode_status;
      o_filter_word <= filter_word;
      o_trim <= trim;
      o_irq <= gen_irq_flag;
      o_reset_req <= reset_event;
      o_osc_monitor_en <= (mode_status == cgsf_pkg::MODE_SELF) && osc_stable_flag &&
                          !i_off_state;
    end
  end

  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_read_arm;
    rd_status_one && gen_irq_flag && !irq_event;
  endsequence
  sequence s_write_one;
    wr_status_one && i_wdata[cgsf_pkg::POS_IRQ] && !irq_event;
  endsequence

  mode_hold_a: assert property (i_mode_write && state == cgsf_pkg::MS_IDLE && !off_exit
    |=> $stable(mode_status) ##1 $stable(mode_status)) else $error("mode status moved early");
  lock_gate_a: assert property (!engaged |=> !lock)
    else $error("lock shown outside engaged mode");
  slip_sets_a: assert property (i_slip_event |=> fll_slip_sticky)
    else $error("slip flag not set");
  loss_sets_a: assert property (i_loss_event |=> ref_loss_sticky)
    else $error("loss flag not set");
  irq_set_a: assert property (irq_event |=> gen_irq_flag && o_irq == $past(gen_irq_flag))
    else $error("interrupt event lost");
  clear_seq_a: assert property (s_read_arm ##1 s_write_one |=> !gen_irq_flag)
    else $error("clear sequence did not clear flag");
  zero_write_a: assert property (wr_status_one && !i_wdata[cgsf_pkg::POS_IRQ] && gen_irq_flag
    |=> gen_irq_flag) else $error("zero write cleared flag");
  filter_ro_a: assert property (!self_select |=> filter_word == $past(i_loop_filter))
    else $error("filter written outside self mode");
  latch_busy_a: assert property (self_select && wr_upper && latch_busy
    |=> filter_word == $past(filter_word)) else $error("upper write taken while busy");
  trim_store_a: assert property (wr_trim |=> trim == $past(i_wdata))
    else $error("trim not stored");
  reset_req_a: assert property (i_slip_event && i_slip_reset_select |=> o_reset_req)
    else $error("slip reset request missing");
  bypass_wait_a: assert property (state == cgsf_pkg::MS_WAIT &&
    target_mode == cgsf_pkg::MODE_BYPASS_EXT && !ext_ref_ok |=> $stable(mode_status))
    else $error("bypass entered without reference");
endmodule
`default_nettype wire

// *** verif/clock_gen_status_filter_trim_bench.sv ***
// Purpose: Self-checking bench for the clock generator status, filter and trim block
// Assumes: Bench drives every port itself, register port strobes one cycle long
// Notes: Expected values come from a small model held in bench variables
`timescale 1ns/1ns
`default_nettype none
module clock_gen_status_filter_trim_bench;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0, i_rd = 1'b0, i_mode_write = 1'b0, i_off_state = 1'b0;
  logic [1:0] i_mode_select = 2'h0;
  logic i_ref_select = 1'b0, i_slip_reset_select = 1'b0, i_ref_loss_reset_select = 1'b0;
  logic i_lock_raw = 1'b0, i_slip_event = 1'b0, i_loss_event = 1'b0;
  logic i_ext_ref_ok_raw = 1'b0, i_err_sample = 1'b0, i_osc_static = 1'b0;
  logic [11:0] i_count_error = 12'h000, i_loop_filter = 12'h000, o_filter_word;
  logic [7:0] o_rdata, o_trim, d, lo, up;
  logic [1:0] o_mode_status, m_ms = 2'h0;
  logic o_irq, o_reset_req, o_osc_monitor_en;
  logic m_slip = 1'b0, m_loss = 1'b0, m_irq = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;

  cgsf_top cgsf_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_mode_select(i_mode_select),
    .i_mode_write(i_mode_write), .i_off_state(i_off_state), .i_ref_select(i_ref_select),
    .i_slip_reset_select(i_slip_reset_select),
    .i_ref_loss_reset_select(i_ref_loss_reset_select), .i_lock_raw(i_lock_raw),
    .i_slip_event(i_slip_event), .i_loss_event(i_loss_event),
    .i_ext_ref_ok_raw(i_ext_ref_ok_raw), .i_err_sample(i_err_sample),
    .i_count_error(i_count_error), .i_osc_static(i_osc_static), .i_loop_filter(i_loop_filter),
    .o_mode_status(o_mode_status), .o_filter_word(o_filter_word), .o_trim(o_trim),
    .o_irq(o_irq), .o_reset_req(o_reset_req), .o_osc_monitor_en(o_osc_monitor_en));

  // Free running 10 MHz clock
  always #50 i_clk = ~i_clk;

  // Verdict and end of run
  task automatic give_verdict();
    $display("errors %0d, compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Register port write and read cycles
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask

  // Status one read, then a flag clear write in the very next cycle
  task automatic rd_clr(output logic [7:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= cgsf_pkg::ADDR_STATUS_ONE;
    @(posedge i_clk);
    i_rd <= 1'b0;
    i_wr <= 1'b1;
    i_wdata <= 8'h01;
    #1 v = o_rdata;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // Status one against the model; lock only in loop engaged modes
  task automatic chk_s1();
    logic [7:0] v;
    rd(cgsf_pkg::ADDR_STATUS_ONE, v);
    chk(12'(v), 12'({m_ms, i_ref_select, m_slip, m_ms[0] & i_lock_raw, m_loss,
      i_ext_ref_ok_raw, m_irq}));
  endtask

  task automatic pulse_slip();
    @(posedge i_clk);
    i_slip_event <= 1'b1;
    @(posedge i_clk);
    i_slip_event <= 1'b0;
  endtask

  task automatic smp(input logic [11:0] v);
    @(posedge i_clk);
    i_err_sample <= 1'b1;
    i_count_error <= v;
    @(posedge i_clk);
    i_err_sample <= 1'b0;
  endtask

  task automatic set_mode(input logic [1:0] m);
    @(posedge i_clk);
    i_mode_select <= m;
    i_mode_write <= 1'b1;
    @(posedge i_clk);
    i_mode_write <= 1'b0;
  endtask

  // Bounded wait for mode status
  task automatic wait_ms(input logic [1:0] m);
    int k;
    k = 0;
    while (o_mode_status !== m && k < 40) begin
      tick(1);
      k++;
    end
    if (o_mode_status !== m) begin
      error_cnt++;
      give_verdict();
    end
  endtask

  // Global watchdog
  initial begin
    repeat (5000) @(posedge i_clk);
    error_cnt++;
    give_verdict();
  end

  // Main sequence
  initial begin
    void'($urandom(64687));
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    i_ref_select <= 1'($urandom);
    i_ext_ref_ok_raw <= 1'($urandom);
    i_loop_filter <= 12'($urandom);
    tick(1);
    chk(12'(o_trim), 12'(cgsf_pkg::TRIM_RESET));
    chk(12'({o_mode_status, o_irq, o_reset_req}), 12'h000);
    chk_s1();
    // Trim byte and unmapped index
    up = 8'($urandom);
    wr(cgsf_pkg::ADDR_PERIOD_ADJUST, up);
    rd(cgsf_pkg::ADDR_PERIOD_ADJUST, d);
    chk(12'(d), 12'(up));
    chk(12'(o_trim), 12'(up));
    rd(3'h5, d);
    chk(12'(d), 12'(cgsf_pkg::READ_IDLE));
    // Static oscillator never counts as stable
    i_osc_static <= 1'b1;
    for (int k = 0; k < 4; k++) smp(12'h100 + 12'(k));
    rd(cgsf_pkg::ADDR_STATUS_TWO, d);
    chk(12'(d), 12'h000);
    i_osc_static <= 1'b0;
    for (int k = 0; k < 4; k++) smp(12'h200 + 12'(k * 4));
    rd(cgsf_pkg::ADDR_STATUS_TWO, d);
    chk(12'(d), 12'h001);
    chk(12'(o_osc_monitor_en), 12'h001);
    i_off_state <= 1'b1;
    tick(2);
    rd(cgsf_pkg::ADDR_STATUS_TWO, d);
    chk(12'(d), 12'h000);
    chk(12'(o_osc_monitor_en), 12'h000);
    i_off_state <= 1'b0;
    // Filter word: lower then upper, second upper during latch ignored
    lo = 8'($urandom);
    up = 8'($urandom);
    wr(cgsf_pkg::ADDR_FILTER_LOWER, lo);
    wr(cgsf_pkg::ADDR_FILTER_UPPER, up);
    wr(cgsf_pkg::ADDR_FILTER_UPPER, up ^ 8'h0F);
    tick(4);
    chk(o_filter_word, {up[3:0], lo});
    rd(cgsf_pkg::ADDR_FILTER_UPPER, d);
    chk(12'(d), 12'(up[3:0]));
    rd(cgsf_pkg::ADDR_FILTER_LOWER, d);
    chk(12'(d), 12'(lo));
    wr(cgsf_pkg::ADDR_FILTER_UPPER, up ^ 8'h05);
    tick(2);
    chk(o_filter_word, {up[3:0] ^ 4'h5, lo});
    // Clock loss with reset select set
    i_ref_loss_reset_select <= 1'b1;
    @(posedge i_clk);
    i_loss_event <= 1'b1;
    @(posedge i_clk);
    i_loss_event <= 1'b0;
    #1 chk(12'(o_reset_req), 12'h001);
    tick(1);
    chk(12'(o_reset_req), 12'h000);
    m_loss = 1'b1;
    chk_s1();
    // Loop slip raises the flag; clearing needs a read while set
    pulse_slip();
    m_slip = 1'b1;
    m_irq = 1'b1;
    tick(1);
    chk(12'(o_irq), 12'h001);
    chk_s1();
    wr(cgsf_pkg::ADDR_STATUS_ONE, 8'h00);
    chk_s1();
    wr(cgsf_pkg::ADDR_STATUS_ONE, 8'h01);
    {m_slip, m_loss, m_irq} = 3'h0;
    tick(2);
    chk(12'(o_irq), 12'h000);
    chk_s1();
    pulse_slip();
    {m_slip, m_irq} = 2'h3;
    wr(cgsf_pkg::ADDR_STATUS_ONE, 8'h01);
    chk_s1();
    pulse_slip();
    wr(cgsf_pkg::ADDR_STATUS_ONE, 8'h01);
    chk_s1();
    wr(cgsf_pkg::ADDR_STATUS_ONE, 8'h01);
    {m_slip, m_irq} = 2'h0;
    tick(2);
    chk(12'(o_irq), 12'h000);
    // Mode switch to loop on internal reference
    set_mode(cgsf_pkg::MODE_LOOP_INT);
    tick(1);
    chk(12'(o_mode_status), 12'(cgsf_pkg::MODE_SELF));
    wait_ms(cgsf_pkg::MODE_LOOP_INT);
    m_ms = cgsf_pkg::MODE_LOOP_INT;
    i_lock_raw <= 1'b1;
    wr(cgsf_pkg::ADDR_FILTER_UPPER, 8'h0A);
    tick(2);
    chk(o_filter_word, i_loop_filter);
    chk_s1();
    // Bypass waits for the external reference
    i_ext_ref_ok_raw <= 1'b0;
    set_mode(cgsf_pkg::MODE_BYPASS_EXT);
    tick(12);
    chk(12'(o_mode_status), 12'(cgsf_pkg::MODE_LOOP_INT));
    i_ext_ref_ok_raw <= 1'b1;
    wait_ms(cgsf_pkg::MODE_BYPASS_EXT);
    m_ms = cgsf_pkg::MODE_BYPASS_EXT;
    tick(2);
    chk_s1();
    // Leaving off with an X1 request waits for the stable flag
    i_off_state <= 1'b1;
    set_mode(cgsf_pkg::MODE_LOOP_EXT);
    tick(6);
    i_off_state <= 1'b0;
    tick(8);
    chk(12'(o_mode_status), 12'(cgsf_pkg::MODE_BYPASS_EXT));
    smp(12'h300);
    smp(12'h302);
    smp(12'h303);
    wait_ms(cgsf_pkg::MODE_LOOP_EXT);
    m_ms = cgsf_pkg::MODE_LOOP_EXT;
    chk_s1();
    // Slip with reset select, loss with interrupt select, then a tight clear
    i_slip_reset_select <= 1'b1;
    i_ref_loss_reset_select <= 1'b0;
    pulse_slip();
    #1 chk(12'(o_reset_req), 12'h001);
    @(posedge i_clk);
    i_loss_event <= 1'b1;
    @(posedge i_clk);
    i_loss_event <= 1'b0;
    tick(1);
    chk(12'(o_irq), 12'h001);
    {m_slip, m_loss, m_irq} = 3'h7;
    rd_clr(d);
    chk(12'(d), 12'({m_ms, i_ref_select, m_slip, m_ms[0] & i_lock_raw, m_loss,
      i_ext_ref_ok_raw, m_irq}));
    #1 chk(12'(o_rdata), 12'(cgsf_pkg::READ_IDLE));
    {m_slip, m_loss, m_irq} = 3'h0;
    tick(2);
    chk(12'(o_irq), 12'h000);
    chk_s1();
    give_verdict();
  end
endmodule
`default_nettype wire
